// file: verilog/uart_irq_ctrl.sv
// Purpose: Interrupt control of a serial controller with host strobe framing
// Assumes: Condition inputs are aclk-synchronous; pins are not
// Notes: AXI4-Lite gives software a status, mask, command and event view
`timescale 1ns/1ps

// Function
// - Active-low interrupt output when enabled condition active
// - Seven recognised interrupting conditions
// - Writable mask, one enable per condition
// - Status view shows raw unmasked conditions
// - Tx write and Rx read clear their interrupts
// - Reset command clears break-change condition
// - Reset command clears multipurpose change condition
// - Stop counter command clears counter condition
// - Clearing the only asserting mask bit negates interrupt output
// - Chip select ORed with strobes frames cycles
// - Timer mode stop only clears counter status
module uart_irq_ctrl (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Host parallel bus strobes
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   // Internal conditions from the serial datapath and counter
   input wire logic tx_holding_ready,
   input wire logic tx_shifter_empty,
   input wire logic rx_char_ready,
   input wire logic rx_queue_full,
   input wire logic break_change,
   input wire logic counter_terminal,
   input wire logic timer_mode,
   // Multipurpose input pin
   input wire logic multipurpose_input,
   // Interrupt outputs
   output logic irq_out_n,
   output logic irq,
   // Host bus cycle view
   output logic host_read_cycle,
   output logic host_write_cycle
);
   logic [6:0] irq_enable_mask_r;
   logic [6:0] irq_status_view;
   logic [6:0] event_r;
   logic [6:0] event_mask_r;
   logic [6:0] event_set;
   logic irq_out_n_r;
   logic irq_r;
   logic [1:0] mpi_sync_r;
   logic mpi_prev_r;
   logic mpi_change_set;
   logic mpi_change;
   logic break_chg;
   logic cnt_ready;
   logic counter_prev_r;
   logic stop_cmd;
   logic brk_clr;
   logic mpi_clr;
   logic tx_written_r;
   logic rx_taken_r;
   logic [1:0] cmd_gap_r;
   logic cmd_ok;
   // Write channel state
   logic aw_held_r;
   logic w_held_r;
   logic [3:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic wr_fire;
   logic [3:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   // Read channel state
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic rd_fire;
   logic [6:0] rd_status_clr;
   // Host strobe framing
   logic rd_active;
   logic wr_active;
   logic host_rd_r;
   logic host_wr_r;

   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
      reg_hit = (addr[3:2] == off[3:2]);
   endfunction

   // Write address and data may arrive in either order; each is held once taken
   assign wr_fire = (aw_held_r | s_axi_awvalid) & (w_held_r | s_axi_wvalid) & !bvalid_r;
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr[3:0];
   assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
   assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr[3:0];
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
      end
   end

   assign s_axi_awready = !aw_held_r & !bvalid_r;
   assign s_axi_wready = !w_held_r & !bvalid_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_addr[3:2] <= 2'h3) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Mask register; clearing the only asserting enable drops the output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_enable_mask_r <= irq_ctrl_pkg::MASK_RESET;
         event_mask_r <= irq_ctrl_pkg::EVENT_RESET;
      end else if (wr_fire & wr_strb[0]) begin
         if (reg_hit(wr_addr, irq_ctrl_pkg::OFF_MASK)) begin
            irq_enable_mask_r <= wr_data[6:0];
         end
         if (reg_hit(wr_addr, irq_ctrl_pkg::OFF_EVENT)) begin
            event_mask_r <= wr_data[6:0];
         end
      end
   end

   // Commands closer than three edges apart are the host's fault; ignore them
   assign cmd_ok = (cmd_gap_r == 2'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_gap_r <= 2'h0;
      end else if (wr_fire & reg_hit(wr_addr, irq_ctrl_pkg::OFF_CMD) & cmd_ok) begin
         cmd_gap_r <= 2'(irq_ctrl_pkg::CMD_GAP_EDGES - 1);
      end else if (cmd_gap_r != 2'h0) begin
         cmd_gap_r <= cmd_gap_r - 2'h1;
      end
   end

   logic cmd_fire;
   logic [3:0] cmd_code;
   assign cmd_fire = wr_fire & wr_strb[0] & reg_hit(wr_addr, irq_ctrl_pkg::OFF_CMD) & cmd_ok;
   assign cmd_code = wr_data[7:4];
   assign brk_clr = cmd_fire & (cmd_code == irq_ctrl_pkg::CMD_RESET_BREAK_CHG);
   assign mpi_clr = cmd_fire & (cmd_code == irq_ctrl_pkg::CMD_RESET_MPI_CHG);
   assign stop_cmd = cmd_fire & (cmd_code == irq_ctrl_pkg::CMD_STOP_COUNTER);

   // Holding-register accesses silence their conditions until the datapath re-raises
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_written_r <= 1'b0;
         rx_taken_r <= 1'b0;
      end else begin
         if (cmd_fire & (cmd_code == irq_ctrl_pkg::CMD_TX_WRITE)) begin
            tx_written_r <= 1'b1;
         end else if (!tx_holding_ready & !tx_shifter_empty) begin
            tx_written_r <= 1'b0;
         end
         if (cmd_fire & (cmd_code == irq_ctrl_pkg::CMD_RX_READ)) begin
            rx_taken_r <= 1'b1;
         end else if (!rx_char_ready & !rx_queue_full) begin
            rx_taken_r <= 1'b0;
         end
      end
   end

   // Multipurpose input passes two flops before any edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mpi_sync_r <= 2'h0;
         mpi_prev_r <= 1'b0;
         counter_prev_r <= 1'b0;
      end else begin
         mpi_sync_r <= {mpi_sync_r[0], multipurpose_input};
         mpi_prev_r <= mpi_sync_r[1];
         counter_prev_r <= counter_terminal;
      end
   end

   assign mpi_change_set = mpi_sync_r[1] ^ mpi_prev_r;

   cond_latch u_mpi_chg (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_in(mpi_change_set),
      .clr_in(mpi_clr),
      .flag(mpi_change)
   );

   cond_latch u_brk_chg (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_in(break_change),
      .clr_in(brk_clr),
      .flag(break_chg)
   );

   // Stop only clears the ready bit; in timer mode counting is untouched
   cond_latch u_cnt_rdy (
      .aclk(aclk),
      .aresetn(aresetn),
      .set_in(counter_terminal & !counter_prev_r),
      .clr_in(stop_cmd),
      .flag(cnt_ready)
   );

   // Raw condition view, never gated by the mask
   always_comb begin
      irq_status_view = 7'h00;
      irq_status_view[irq_ctrl_pkg::BIT_TX_READY] = tx_holding_ready & !tx_written_r;
      irq_status_view[irq_ctrl_pkg::BIT_TX_EMPTY] = tx_shifter_empty & !tx_written_r;
      irq_status_view[irq_ctrl_pkg::BIT_RX_READY] = (rx_char_ready | rx_queue_full) & !rx_taken_r;
      irq_status_view[irq_ctrl_pkg::BIT_BREAK_CHG] = break_chg;
      irq_status_view[irq_ctrl_pkg::BIT_CNT_READY] = cnt_ready;
      irq_status_view[irq_ctrl_pkg::BIT_MPI_CHG] = mpi_change;
      irq_status_view[irq_ctrl_pkg::BIT_MPI_ASSERT] = mpi_sync_r[1] & mpi_prev_r;
   end

   // Sticky event log of condition rises, the MPI change rise only while mpi_prev_r is low; a read clears it, a new rise wins
   assign event_set = irq_status_view & ~{1'b0, mpi_prev_r, 5'h00};

   logic [6:0] status_prev_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_prev_r <= 7'h00;
         event_r <= irq_ctrl_pkg::EVENT_RESET;
      end else begin
         status_prev_r <= irq_status_view;
         event_r <= (event_r & ~rd_status_clr) | (event_set & ~status_prev_r);
      end
   end

   // irq_out_n from the AND of status and mask, irq from the AND of events and event mask; flopped so both leave a register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out_n_r <= 1'b1;
         irq_r <= 1'b0;
      end else begin
         irq_out_n_r <= !(|(irq_status_view & irq_enable_mask_r));
         irq_r <= |(event_r & event_mask_r);
      end
   end

   assign irq_out_n = irq_out_n_r;
   assign irq = irq_r;

   // Read channel
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign s_axi_arready = !rvalid_r;
   assign rd_status_clr = (rd_fire & reg_hit(s_axi_araddr[3:0], irq_ctrl_pkg::OFF_EVENT) &
                           (s_axi_araddr[31:4] == 28'h0000000)) ? 7'h7F : 7'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= 2'h0;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rresp_r <= 2'h0;
         case (s_axi_araddr[3:2])
            2'h0: rdata_r <= {25'h0000000, irq_status_view};
            2'h1: rdata_r <= {25'h0000000, irq_enable_mask_r};
            2'h2: rdata_r <= {30'h00000000, cmd_gap_r};
            2'h3: rdata_r <= {16'h0000, 1'b0, event_mask_r, 1'b0, event_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
         if (s_axi_araddr[31:4] != 28'h0000000) begin
            rresp_r <= 2'h2;
            rdata_r <= 32'h0000_0000;
         end
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Host parallel bus framing
   strobe_frame u_rd_frame (
      .aclk(aclk),
      .aresetn(aresetn),
      .chip_select_n(chip_select_n),
      .strobe_n(read_strobe_n),
      .active(rd_active),
      .start_pulse(),
      .end_pulse()
   );

   strobe_frame u_wr_frame (
      .aclk(aclk),
      .aresetn(aresetn),
      .chip_select_n(chip_select_n),
      .strobe_n(write_strobe_n),
      .active(wr_active),
      .start_pulse(),
      .end_pulse()
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         host_rd_r <= 1'b0;
         host_wr_r <= 1'b0;
      end else begin
         host_rd_r <= rd_active;
         host_wr_r <= wr_active;
      end
   end

   assign host_read_cycle = host_rd_r;
   assign host_write_cycle = host_wr_r;
endmodule

// file: shared/irq_ctrl_pkg.sv
// Purpose: Constants shared by the interrupt control block and its helpers
// Assumes: 32-bit AXI4-Lite register bus, 40 MHz aclk
// Notes: Register offsets are byte addresses of aligned words
package irq_ctrl_pkg;
   // Register byte offsets
   localparam logic [3:0] OFF_STATUS = 4'h0;
   localparam logic [3:0] OFF_MASK = 4'h4;
   localparam logic [3:0] OFF_CMD = 4'h8;
   localparam logic [3:0] OFF_EVENT = 4'hC;
   // Status bit positions
   localparam int BIT_TX_READY = 0;
   localparam int BIT_TX_EMPTY = 1;
   localparam int BIT_RX_READY = 2;
   localparam int BIT_BREAK_CHG = 3;
   localparam int BIT_CNT_READY = 4;
   localparam int BIT_MPI_CHG = 5;
   localparam int BIT_MPI_ASSERT = 6;
   localparam int NUM_COND = 7;
   // Reset values
   localparam logic [6:0] MASK_RESET = 7'h00;
   localparam logic [6:0] EVENT_RESET = 7'h00;
   // Command codes written to the command register, bits 7:4
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_RESET_BREAK_CHG = 4'h5;
   localparam logic [3:0] CMD_RESET_MPI_CHG = 4'h4;
   localparam logic [3:0] CMD_STOP_COUNTER = 4'h9;
   localparam logic [3:0] CMD_TX_WRITE = 4'hA;
   localparam logic [3:0] CMD_RX_READ = 4'hB;
   // Host strobe timing
   localparam int CLK_HZ = 40000000;
   localparam int CMD_GAP_EDGES = 3;
   localparam int STROBE_MIN_NS = 150;
   localparam int STROBE_MIN_CYC =
      (STROBE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
endpackage

// file: verilog/strobe_frame.sv
// Purpose: Frame host bus cycles from chip select and read/write strobes
// Assumes: Strobes arrive asynchronously and are active low
// Notes: Emits one-cycle start and end pulses per framed cycle
`timescale 1ns/1ps
module strobe_frame (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Host pins
   input wire logic chip_select_n,
   input wire logic strobe_n,
   // Framed cycle
   output logic active,
   output logic start_pulse,
   output logic end_pulse
);
   logic [1:0] cs_sync_r;
   logic [1:0] st_sync_r;
   logic active_r;
   logic cyc_nxt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cs_sync_r <= 2'h3;
         st_sync_r <= 2'h3;
      end else begin
         cs_sync_r <= {cs_sync_r[0], chip_select_n};
         st_sync_r <= {st_sync_r[0], strobe_n};
      end
   end

   // Later assertion starts, earlier negation ends: an OR of active lows
   assign cyc_nxt = !(cs_sync_r[1] | st_sync_r[1]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_r <= 1'b0;
      end else begin
         active_r <= cyc_nxt;
      end
   end

   assign active = active_r;
   assign start_pulse = cyc_nxt & !active_r;
   assign end_pulse = !cyc_nxt & active_r;
endmodule

// file: verilog/cond_latch.sv
// Purpose: One sticky interrupting condition with a set and a clear
// Assumes: Set and clear are single-cycle pulses on aclk
// Notes: Set wins over a clear in the same cycle so no event is lost
`timescale 1ns/1ps
module cond_latch (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic set_in,
   input wire logic clr_in,
   // State
   output logic flag
);
   logic flag_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_r <= 1'b0;
      end else if (set_in) begin
         flag_r <= 1'b1;
      end else if (clr_in) begin
         flag_r <= 1'b0;
      end
   end

   assign flag = flag_r;
endmodule

// file: tb/uart_irq_ctrl_properties.sv
// Purpose: Concurrent checks on the ports of the interrupt control block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Strobe windows of five samples allow for the four-cycle framing delay
`timescale 1ns/1ps
module uart_irq_ctrl_properties (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Host pins and outputs
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic irq_out_n,
   input wire logic irq,
   input wire logic host_read_cycle,
   input wire logic host_write_cycle
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_mask_off;
      s_wr_take ##0 s_axi_awaddr == 32'(irq_ctrl_pkg::OFF_MASK) && s_axi_wstrb[0]
         && s_axi_wdata[6:0] == 7'h00;
   endsequence
   property p_reset;
      disable iff (1'b0) !aresetn |=> irq_out_n && !irq && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   property p_rd_cycle;
      (!chip_select_n && !read_strobe_n)[*5] |-> host_read_cycle;
   endproperty
   property p_wr_cycle;
      (!chip_select_n && !write_strobe_n)[*5] |-> host_write_cycle;
   endproperty
   property p_no_cycle;
      (chip_select_n || (read_strobe_n && write_strobe_n))[*5]
         |-> !host_read_cycle && !host_write_cycle;
   endproperty
   property p_mask_off;
      s_mask_off |-> ##[1:3] irq_out_n;
   endproperty
   property p_b_answer;
      s_wr_take |=> s_axi_bvalid;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_r_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[31:4] != 28'h0
         |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not idle after reset");
   a_rd_cycle: assert property (p_rd_cycle) else $error("read cycle not framed");
   a_wr_cycle: assert property (p_wr_cycle) else $error("write cycle not framed");
   a_no_cycle: assert property (p_no_cycle) else $error("cycle without both strobes");
   a_mask_off: assert property (p_mask_off) else $error("irq kept after mask clear");
   a_b_answer: assert property (p_b_answer) else $error("write not answered");
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");
endmodule

bind uart_irq_ctrl uart_irq_ctrl_properties chk (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n, .read_strobe_n,
   .write_strobe_n, .irq_out_n, .irq, .host_read_cycle, .host_write_cycle);

// file: tb/host_cpu_model.sv
// Purpose: Host processor model driving the parallel bus strobes
// Assumes: Pins idle high when released, as with pull-ups
// Notes: Either select or strobe can be the later edge of a cycle
`timescale 1ns/1ps
module host_cpu_model (
   // Clock
   input wire logic aclk,
   // Host pins
   output logic chip_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n
);
   initial begin
      chip_select_n = 1'b1;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
   end
   // Later assertion opens the cycle, earlier release closes it
   task automatic cycle(input logic wr, input logic cs_last, input int len);
      @(posedge aclk);
      if (cs_last) begin
         read_strobe_n <= wr;
         write_strobe_n <= !wr;
      end else begin
         chip_select_n <= 1'b0;
      end
      @(posedge aclk);
      chip_select_n <= 1'b0;
      read_strobe_n <= wr;
      write_strobe_n <= !wr;
      repeat (len) @(posedge aclk);
      if (cs_last) begin
         chip_select_n <= 1'b1;
      end else begin
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
      end
      @(posedge aclk);
      chip_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      // Idle gap before the next access
      repeat (3) @(posedge aclk);
   endtask
endmodule

// file: tb/test_uart_irq_ctrl.sv
// Purpose: Self-checking bench for the interrupt control block
// Assumes: 40 MHz aclk, synchronous active-low reset
// Notes: Status rows first, then command, reset, event and strobe cases
`timescale 1ns/1ps
module test_uart_irq_ctrl;
   typedef struct {logic [3:0] c; logic [6:0] m; logic [31:0] s; logic n;} row_t;
   row_t rows [6] = '{'{4'h1, 7'h04, 32'h04, 1'b0}, '{4'h2, 7'h00, 32'h04, 1'b1},
      '{4'h4, 7'h02, 32'h02, 1'b0}, '{4'h8, 7'h01, 32'h01, 1'b0},
      '{4'h8, 7'h02, 32'h01, 1'b1}, '{4'h0, 7'h7F, 32'h00, 1'b1}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [3:0] cnd = 4'h0;
   logic break_change = 1'b0, counter_terminal = 1'b0, timer_mode = 1'b0;
   logic multipurpose_input = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic chip_select_n, read_strobe_n, write_strobe_n;
   logic irq_out_n, irq, host_read_cycle, host_write_cycle;
   logic [31:0] q;
   int mismatches = 0;
   int checked = 0;
   always #12.5 aclk = !aclk;
   host_cpu_model host (.aclk, .chip_select_n, .read_strobe_n, .write_strobe_n);
   uart_irq_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n, .read_strobe_n,
      .write_strobe_n, .tx_holding_ready(cnd[3]), .tx_shifter_empty(cnd[2]),
      .rx_char_ready(cnd[1]), .rx_queue_full(cnd[0]), .break_change, .counter_terminal,
      .timer_mode, .multipurpose_input, .irq_out_n, .irq, .host_read_cycle, .host_write_cycle);
   task automatic finish_test();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Ready and answer are sampled before the edge so each handshake closes on that edge
   task automatic axi(input logic w, input logic [31:0] a, d, output logic [31:0] rq,
      output logic [1:0] rr);
      int n;
      logic ra, rb, done;
      n = 0;
      done = 1'b0;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      while (!done) begin
         @(negedge aclk);
         ra = w ? s_axi_awready : s_axi_arready;
         rb = s_axi_wready;
         done = w ? s_axi_bvalid : s_axi_rvalid;
         rq = s_axi_rdata;
         rr = w ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         if (ra) begin
            s_axi_awvalid <= 1'b0;
            s_axi_arvalid <= 1'b0;
         end
         if (rb) s_axi_wvalid <= 1'b0;
         n++;
         if (n > 100) begin
            mismatches++;
            finish_test();
         end
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask
   task automatic reg_wr(input logic [3:0] o, input logic [31:0] d);
      axi(1'b1, 32'(o), d, q, rs);
      chk(32'(rs), 32'h0);
   endtask
   task automatic reg_rd(input logic [3:0] o, input logic [31:0] e);
      axi(1'b0, 32'(o), 32'h0, q, rs);
      chk(32'(rs), 32'h0);
      chk(q, e);
   endtask
   task automatic cmd(input logic [3:0] k);
      reg_wr(irq_ctrl_pkg::OFF_CMD, {24'h0, k, 4'h0});
      repeat (3) @(posedge aclk);
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge aclk);
   endtask
   task automatic brk();
      @(posedge aclk);
      break_change <= 1'b1;
      @(posedge aclk);
      break_change <= 1'b0;
      tick(4);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      reg_rd(irq_ctrl_pkg::OFF_MASK, 32'(irq_ctrl_pkg::MASK_RESET));
      foreach (rows[i]) begin
         @(posedge aclk);
         cnd <= rows[i].c;
         reg_wr(irq_ctrl_pkg::OFF_MASK, 32'(rows[i].m));
         tick(4);
         reg_rd(irq_ctrl_pkg::OFF_STATUS, rows[i].s);
         chk(32'(irq_out_n), 32'(rows[i].n));
      end
      brk();
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h08);
      cmd(irq_ctrl_pkg::CMD_RESET_BREAK_CHG);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h00);
      @(posedge aclk);
      timer_mode <= 1'b1;
      counter_terminal <= 1'b1;
      tick(4);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h10);
      cmd(irq_ctrl_pkg::CMD_STOP_COUNTER);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h00);
      counter_terminal <= 1'b0;
      multipurpose_input <= 1'b1;
      tick(8);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h60);
      cmd(irq_ctrl_pkg::CMD_RESET_MPI_CHG);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h40);
      chk(32'(irq_out_n), 32'h0);
      multipurpose_input <= 1'b0;
      cnd <= 4'hC;
      tick(8);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h23);
      cmd(irq_ctrl_pkg::CMD_RESET_MPI_CHG);
      cmd(irq_ctrl_pkg::CMD_TX_WRITE);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h00);
      cnd <= 4'h2;
      tick(4);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h04);
      cmd(irq_ctrl_pkg::CMD_RX_READ);
      reg_rd(irq_ctrl_pkg::OFF_STATUS, 32'h00);
      chk(32'(irq_out_n), 32'h1);
      cnd <= 4'h0;
      reg_wr(irq_ctrl_pkg::OFF_MASK, 32'h08);
      brk();
      chk(32'(irq_out_n), 32'h0);
      reg_wr(irq_ctrl_pkg::OFF_MASK, 32'h00);
      tick(3);
      chk(32'(irq_out_n), 32'h1);
      reg_wr(irq_ctrl_pkg::OFF_MASK, 32'h08);
      tick(3);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      tick(1);
      chk(32'(irq_out_n), 32'h1);
      @(posedge aclk);
      aresetn <= 1'b1;
      reg_rd(irq_ctrl_pkg::OFF_MASK, 32'h00);
      reg_rd(irq_ctrl_pkg::OFF_EVENT, 32'h00);
      reg_wr(irq_ctrl_pkg::OFF_EVENT, 32'h08);
      brk();
      chk(32'(irq), 32'h1);
      reg_rd(irq_ctrl_pkg::OFF_EVENT, 32'h0808);
      tick(3);
      chk(32'(irq), 32'h0);
      cmd(irq_ctrl_pkg::CMD_RESET_BREAK_CHG);
      reg_wr(irq_ctrl_pkg::OFF_EVENT, 32'h00);
      brk();
      chk(32'(irq), 32'h0);
      axi(1'b0, 32'h10, 32'h0, q, rs);
      chk({q[29:0], rs}, 32'h2);
      for (int i = 0; i < 4; i++) begin
         fork
            host.cycle(i[0], i[1], 6);
            begin
               int n;
               n = 0;
               while ((i[0] ? host_write_cycle : host_read_cycle) !== 1'b1 && n < 12) begin
                  tick(1);
                  n++;
               end
               chk({host_read_cycle, host_write_cycle}, {!i[0], i[0]});
            end
         join
         // The model returns on the edge that drops the cycle flag
         tick(1);
         chk({host_read_cycle, host_write_cycle}, 32'h0);
      end
      finish_test();
   end
endmodule
